// [inc/oag_pkg.sv]
// Constants, types and helpers for operand fetch and effective-address generation
// Overview of operation
// RULE_01 - Extended immediate comes from following 16-bit word
// RULE_02 - Eight-bit immediate from instruction low byte
// RULE_03 - Four-bit immediate from low byte's upper nibble
// RULE_04 - Register-direct data stays within lower 64K
// RULE_05 - Register jump loads PC, drives A16-A1, A0=0
// RULE_06 - Byte into register is zero-extended
// RULE_07 - Predecrement by size, then access
// RULE_08 - Access, then postincrement by size
// RULE_09 - Displacement plus register, register unchanged
// RULE_10 - Indirect value is byte address, except jumps; code also uses it as a word address for far moves
// RULE_11 - Predecrement only for move to register
// RULE_12 - Byte store touches only addressed byte
// RULE_13 - Displaced jump reads word address into PC
// RULE_14 - Displaced data stays within lower 64K
// RULE_15 - Pointer update applied once per instruction
package oag_pkg;
	localparam int          OAG_DW        = 16;
	localparam int          OAG_AW        = 17;
	localparam int          OAG_IMM8_MSB  = 7;
	localparam int          OAG_IMM4_MSB  = 7;
	localparam int          OAG_IMM4_LSB  = 4;
	localparam int          OAG_BYTE_MSB  = 7;
	localparam logic [15:0] OAG_STEP_WORD = 16'h0002;
	localparam logic [15:0] OAG_STEP_BYTE = 16'h0001;
	localparam logic [15:0] OAG_WORD_RST  = 16'h0000;
	localparam logic [7:0]  OAG_ZERO_BYTE = 8'h00;
	localparam logic        OAG_LOW_PAGE  = 1'b0;
	localparam logic        OAG_A0_WORD   = 1'b0;
	localparam logic [1:0]  OAG_BE_NONE   = 2'h0;
	localparam logic [1:0]  OAG_BE_WORD   = 2'h3;
	localparam logic [1:0]  OAG_BE_HIGH   = 2'h2;
	localparam logic [1:0]  OAG_BE_LOW    = 2'h1;

	typedef enum logic [2:0] {
		OAG_M_IMM16   = 3'h0,
		OAG_M_IMM8    = 3'h1,
		OAG_M_IMM4    = 3'h2,
		OAG_M_REG     = 3'h3,
		OAG_M_IND     = 3'h4,
		OAG_M_PREDEC  = 3'h5,
		OAG_M_POSTINC = 3'h6,
		OAG_M_DISP    = 3'h7
	} oag_mode_t;

	typedef enum logic [1:0] {
		OAG_K_DATA = 2'h0,
		OAG_K_JUMP = 2'h1,
		OAG_K_FAR_MOVE_INSTRUCTION = 2'h2
	} oag_kind_t;

	typedef enum logic {
		OAG_S_IDLE = 1'b0,
		OAG_S_MEM  = 1'b1
	} oag_state_t;

	function automatic logic [15:0] oag_step(input logic byte_op);
		oag_step = byte_op ? OAG_STEP_BYTE : OAG_STEP_WORD;
	endfunction : oag_step

	function automatic logic [15:0] oag_zext(input logic [7:0] b);
		oag_zext = {OAG_ZERO_BYTE, b};
	endfunction : oag_zext

	// Odd byte address is the low byte of the word
	function automatic logic [7:0] oag_lane(input logic [15:0] w, input logic a0);
		oag_lane = a0 ? w[7:0] : w[15:8];
	endfunction : oag_lane
endpackage : oag_pkg

// [inc/oag_ea_if.sv]
// Effective-address request and result between the sequencer and the adder
`timescale 1ns/10ps
interface oag_ea_if;
	oag_pkg::oag_mode_t mode;
	logic               byte_op;
	logic [15:0]        base;
	logic [15:0]        disp;
	logic [15:0]        ea;
	logic [15:0]        ptr_next;
	logic               ptr_upd;

	modport calc (input mode, input byte_op, input base, input disp, output ea, output ptr_next, output ptr_upd);
	modport user (output mode, output byte_op, output base, output disp, input ea, input ptr_next, input ptr_upd);
endinterface : oag_ea_if

// [core/oag_ea_calc.sv]
// Effective-address adder with pointer pre/post adjustment
`timescale 1ns/10ps
module oag_ea_calc (
	oag_ea_if.calc ea_if
);
	logic [15:0] step;
	logic [15:0] dec_ptr;
	logic [15:0] inc_ptr;

	assign step    = oag_pkg::oag_step(ea_if.byte_op);
	assign dec_ptr = ea_if.base - step;
	assign inc_ptr = ea_if.base + step;

	always_comb begin
		ea_if.ea       = ea_if.base;
		ea_if.ptr_next = ea_if.base;
		ea_if.ptr_upd  = 1'b0;
		unique case (ea_if.mode)
			oag_pkg::OAG_M_PREDEC: begin
				ea_if.ea       = dec_ptr; // RULE_07
				ea_if.ptr_next = dec_ptr; // RULE_07
				ea_if.ptr_upd  = 1'b1;
			end
			oag_pkg::OAG_M_POSTINC: begin
				ea_if.ptr_next = inc_ptr; // RULE_08
				ea_if.ptr_upd  = 1'b1;
			end
			// Register itself is never written back here
			oag_pkg::OAG_M_DISP: ea_if.ea = ea_if.disp + ea_if.base; // RULE_09
			default: ea_if.ea = ea_if.base;
		endcase
	end
endmodule : oag_ea_calc

// [core/oag_imm_ext.sv]
// Immediate operand extraction from instruction or extension word
`timescale 1ns/10ps
module oag_imm_ext (
	input  wire logic [15:0]        i_iw,
	input  wire logic [15:0]        i_ext,
	input  wire oag_pkg::oag_mode_t i_mode,
	output logic      [15:0]        o_imm
);
	always_comb begin
		unique case (i_mode)
			oag_pkg::OAG_M_IMM8: o_imm = oag_pkg::oag_zext(i_iw[oag_pkg::OAG_IMM8_MSB:0]); // RULE_02
			oag_pkg::OAG_M_IMM4: o_imm = {12'h000, i_iw[oag_pkg::OAG_IMM4_MSB:oag_pkg::OAG_IMM4_LSB]}; // RULE_03
			default:             o_imm = i_ext; // RULE_01
		endcase
	end
endmodule : oag_imm_ext

// [core/oag_core.sv]
// Operand fetch and effective-address sequencer
`timescale 1ns/10ps
module oag_core (
	input  wire logic               i_clk,
	input  wire logic               i_rst_n,
	input  wire logic               i_start,
	input  wire logic [15:0]        i_iw,
	input  wire logic [15:0]        i_ext,
	input  wire oag_pkg::oag_mode_t i_mode,
	input  wire oag_pkg::oag_kind_t i_kind,
	input  wire logic               i_byte,
	input  wire logic               i_is_move,
	input  wire logic               i_dst_mem,
	input  wire logic [15:0]        i_reg_val,
	input  wire logic [15:0]        i_store_data,
	input  wire logic               i_mem_ack,
	input  wire logic [15:0]        i_mem_rdata,
	output logic                    o_busy,
	output logic                    o_mem_req,
	output logic      [16:0]        o_mem_addr,
	output logic                    o_mem_we,
	output logic      [1:0]         o_mem_be,
	output logic      [15:0]        o_mem_wdata,
	output logic                    o_result_vld,
	output logic      [15:0]        o_result,
	output logic                    o_ptr_we,
	output logic      [15:0]        o_ptr_wdata,
	output logic                    o_pc_we,
	output logic      [15:0]        o_pc,
	output logic      [16:0]        o_fetch_addr,
	output logic                    o_illegal
);
	oag_ea_if ea_if ();

	logic [15:0] imm;

	oag_imm_ext u_imm (
		.i_iw   (i_iw),
		.i_ext  (i_ext),
		.i_mode (i_mode),
		.o_imm  (imm)
	);

	oag_ea_calc u_ea (
		.ea_if (ea_if)
	);

	// Address is formed in the start cycle from the live request
	assign ea_if.mode    = i_mode;
	assign ea_if.byte_op = i_byte;
	assign ea_if.base    = i_reg_val;
	assign ea_if.disp    = i_ext;

	oag_pkg::oag_state_t state;
	oag_pkg::oag_state_t next_state;
	oag_pkg::oag_kind_t  kind;
	oag_pkg::oag_kind_t  next_kind;
	logic                byte_op;
	logic                next_byte_op;
	logic                ptr_pend;
	logic                next_ptr_pend;
	logic [15:0]         ptr_val;
	logic [15:0]         next_ptr_val;

	logic                next_busy;
	logic                next_mem_req;
	logic [16:0]         next_mem_addr;
	logic                next_mem_we;
	logic [1:0]          next_mem_be;
	logic [15:0]         next_mem_wdata;
	logic                next_result_vld;
	logic [15:0]         next_result;
	logic                next_ptr_we;
	logic [15:0]         next_ptr_wdata;
	logic                next_pc_we;
	logic [15:0]         next_pc;
	logic [16:0]         next_fetch_addr;
	logic                next_illegal;

	logic                is_ind;
	logic                predec_ok;

	assign is_ind    = (i_mode == oag_pkg::OAG_M_IND) || (i_mode == oag_pkg::OAG_M_PREDEC) ||
	                   (i_mode == oag_pkg::OAG_M_POSTINC) || (i_mode == oag_pkg::OAG_M_DISP);
	assign predec_ok = (i_kind == oag_pkg::OAG_K_DATA) && i_is_move && !i_dst_mem;

	always_comb begin
		next_state      = state;
		next_kind       = kind;
		next_byte_op    = byte_op;
		next_ptr_pend   = ptr_pend;
		next_ptr_val    = ptr_val;
		next_busy       = o_busy;
		next_mem_req    = o_mem_req;
		next_mem_addr   = o_mem_addr;
		next_mem_we     = o_mem_we;
		next_mem_be     = o_mem_be;
		next_mem_wdata  = o_mem_wdata;
		next_result     = o_result;
		next_pc         = o_pc;
		next_fetch_addr = o_fetch_addr;
		next_ptr_wdata  = o_ptr_wdata;
		next_result_vld = 1'b0;
		next_ptr_we     = 1'b0;
		next_pc_we      = 1'b0;
		next_illegal    = 1'b0;
		unique case (state)
			oag_pkg::OAG_S_IDLE: begin
				if (i_start) begin
					next_kind    = i_kind;
					next_byte_op = i_byte;
					if (i_mode == oag_pkg::OAG_M_IMM16 || i_mode == oag_pkg::OAG_M_IMM8 ||
					    i_mode == oag_pkg::OAG_M_IMM4) begin
						next_result     = imm; // RULE_01
						next_result_vld = 1'b1;
					end else if (i_mode == oag_pkg::OAG_M_REG) begin
						if (i_kind == oag_pkg::OAG_K_JUMP) begin
							next_pc         = i_reg_val; // RULE_05
							next_pc_we      = 1'b1;
							next_fetch_addr = {i_reg_val, oag_pkg::OAG_A0_WORD}; // RULE_05
						end else begin
							// Data operands never leave the lower 64K
							next_result     = i_byte ? oag_pkg::oag_zext(i_reg_val[oag_pkg::OAG_BYTE_MSB:0])
							                         : i_reg_val; // RULE_04 RULE_06
							next_result_vld = 1'b1;
						end
					end else if (is_ind) begin
						if (i_mode == oag_pkg::OAG_M_PREDEC && !predec_ok) begin
							// Unsupported form: no access, pointer untouched
							next_illegal = 1'b1; // RULE_11
						end else if (i_kind == oag_pkg::OAG_K_JUMP && i_mode != oag_pkg::OAG_M_DISP) begin
							next_pc         = ea_if.ea; // RULE_10
							next_pc_we      = 1'b1;
							next_fetch_addr = {ea_if.ea, oag_pkg::OAG_A0_WORD}; // RULE_10
							next_ptr_we     = ea_if.ptr_upd; // RULE_15
							next_ptr_wdata  = ea_if.ptr_next;
						end else begin
							next_state    = oag_pkg::OAG_S_MEM;
							next_busy     = 1'b1;
							next_mem_req  = 1'b1;
							next_ptr_pend = ea_if.ptr_upd;
							next_ptr_val  = ea_if.ptr_next;
							if (i_kind == oag_pkg::OAG_K_FAR_MOVE_INSTRUCTION) begin
								next_mem_addr = {ea_if.ea, oag_pkg::OAG_A0_WORD}; // RULE_10
								next_mem_be   = oag_pkg::OAG_BE_WORD;
							end else begin
								// Displaced jump table also lives in the lower 64K
								next_mem_addr = {oag_pkg::OAG_LOW_PAGE, ea_if.ea}; // RULE_10 RULE_14
								if (!i_byte) begin
									next_mem_be = oag_pkg::OAG_BE_WORD;
								end else if (ea_if.ea[0]) begin
									next_mem_be = oag_pkg::OAG_BE_LOW; // RULE_12
								end else begin
									next_mem_be = oag_pkg::OAG_BE_HIGH; // RULE_12
								end
							end
							next_mem_we = i_dst_mem && (i_kind != oag_pkg::OAG_K_JUMP);
							// Byte replicated on both lanes; strobe picks the one that lands
							next_mem_wdata = i_byte ? {i_store_data[7:0], i_store_data[7:0]}
							                        : i_store_data; // RULE_12
						end
					end
				end
			end
			oag_pkg::OAG_S_MEM: begin
				if (i_mem_ack) begin
					next_state   = oag_pkg::OAG_S_IDLE;
					next_busy    = 1'b0;
					next_mem_req = 1'b0;
					next_mem_we  = 1'b0;
					next_mem_be  = oag_pkg::OAG_BE_NONE;
					if (kind == oag_pkg::OAG_K_JUMP) begin
						next_pc         = i_mem_rdata; // RULE_13
						next_pc_we      = 1'b1;
						next_fetch_addr = {i_mem_rdata, oag_pkg::OAG_A0_WORD}; // RULE_13
					end else if (!o_mem_we) begin
						next_result     = (byte_op && kind == oag_pkg::OAG_K_DATA)
						                  ? oag_pkg::oag_zext(oag_pkg::oag_lane(i_mem_rdata, o_mem_addr[0]))
						                  : i_mem_rdata; // RULE_06
						next_result_vld = 1'b1;
					end
					// Write-back after the access, once
					next_ptr_we    = ptr_pend; // RULE_08 RULE_15
					next_ptr_wdata = ptr_val;
					next_ptr_pend  = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state        <= oag_pkg::OAG_S_IDLE;
			kind         <= oag_pkg::OAG_K_DATA;
			byte_op      <= 1'b0;
			ptr_pend     <= 1'b0;
			ptr_val      <= oag_pkg::OAG_WORD_RST;
			o_busy       <= 1'b0;
			o_mem_req    <= 1'b0;
			o_mem_addr   <= 17'h00000;
			o_mem_we     <= 1'b0;
			o_mem_be     <= oag_pkg::OAG_BE_NONE;
			o_mem_wdata  <= oag_pkg::OAG_WORD_RST;
			o_result_vld <= 1'b0;
			o_result     <= oag_pkg::OAG_WORD_RST;
			o_ptr_we     <= 1'b0;
			o_ptr_wdata  <= oag_pkg::OAG_WORD_RST;
			o_pc_we      <= 1'b0;
			o_pc         <= oag_pkg::OAG_WORD_RST;
			o_fetch_addr <= 17'h00000;
			o_illegal    <= 1'b0;
		end else begin
			state        <= next_state;
			kind         <= next_kind;
			byte_op      <= next_byte_op;
			ptr_pend     <= next_ptr_pend;
			ptr_val      <= next_ptr_val;
			o_busy       <= next_busy;
			o_mem_req    <= next_mem_req;
			o_mem_addr   <= next_mem_addr;
			o_mem_we     <= next_mem_we;
			o_mem_be     <= next_mem_be;
			o_mem_wdata  <= next_mem_wdata;
			o_result_vld <= next_result_vld;
			o_result     <= next_result;
			o_ptr_we     <= next_ptr_we;
			o_ptr_wdata  <= next_ptr_wdata;
			o_pc_we      <= next_pc_we;
			o_pc         <= next_pc;
			o_fetch_addr <= next_fetch_addr;
			o_illegal    <= next_illegal;
		end
	end
endmodule : oag_core

// [test/oag_mem_model.sv]
// Behavioural memory on the far side of the core's address bus
`timescale 1ns/10ps
module oag_mem_model (
	input  wire logic        i_clk,
	input  wire logic        i_req,
	input  wire logic [16:0] i_addr,
	input  wire logic        i_we,
	input  wire logic [1:0]  i_be,
	input  wire logic [15:0] i_wdata,
	input  wire logic [3:0]  i_lat,
	output logic             o_ack,
	output logic      [15:0] o_rdata
);
	logic [15:0] mem [256];
	int          wait_cnt = 0;
	initial o_ack = 1'b0;
	initial o_rdata = 16'h0000;
	always @(posedge i_clk) begin
		if (o_ack || !i_req) begin
			o_ack <= 1'b0;
			wait_cnt <= 0;
			// Released bus inverts its read data every cycle, so the old word shows again every other idle cycle
			o_rdata <= ~o_rdata;
		end else if (wait_cnt < i_lat) begin
			wait_cnt <= wait_cnt + 1;
		end else begin
			o_ack <= 1'b1;
			o_rdata <= mem[i_addr[8:1]];
			if (i_we && i_be[1])
				mem[i_addr[8:1]][15:8] <= i_wdata[15:8];
			if (i_we && i_be[0])
				mem[i_addr[8:1]][7:0] <= i_wdata[7:0];
		end
	end
endmodule : oag_mem_model

// [test/oag_core_checker.sv]
// Port-level assertions for the operand address sequencer
`timescale 1ns/10ps
module oag_core_checker (
	input wire logic               i_clk,
	input wire logic               i_rst_n,
	input wire logic               i_start,
	input wire logic [15:0]        i_iw,
	input wire logic [15:0]        i_ext,
	input wire oag_pkg::oag_mode_t i_mode,
	input wire oag_pkg::oag_kind_t i_kind,
	input wire logic               i_is_move,
	input wire logic               i_dst_mem,
	input wire logic [15:0]        i_reg_val,
	input wire logic               o_busy,
	input wire logic               o_mem_req,
	input wire logic [16:0]        o_mem_addr,
	input wire logic               o_mem_we,
	input wire logic [1:0]         o_mem_be,
	input wire logic [15:0]        o_mem_wdata,
	input wire logic               o_result_vld,
	input wire logic [15:0]        o_result,
	input wire logic               o_pc_we,
	input wire logic [15:0]        o_pc,
	input wire logic [16:0]        o_fetch_addr,
	input wire logic               o_illegal
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	wire take = i_start && !o_busy;
	wire data = i_kind == oag_pkg::OAG_K_DATA;
	property p_imm16;
		take && i_mode == oag_pkg::OAG_M_IMM16 |=> o_result_vld && o_result == $past(i_ext);
	endproperty
	a_imm16: assert property (p_imm16) else $error("imm16 operand wrong");
	property p_imm8;
		take && i_mode == oag_pkg::OAG_M_IMM8 |=> o_result_vld && o_result == {8'h00, $past(i_iw[7:0])};
	endproperty
	a_imm8: assert property (p_imm8) else $error("imm8 operand wrong");
	property p_imm4;
		take && i_mode == oag_pkg::OAG_M_IMM4 |=> o_result_vld && o_result == {12'h000, $past(i_iw[7:4])};
	endproperty
	a_imm4: assert property (p_imm4) else $error("imm4 operand wrong");
	property p_regjmp;
		take && i_mode == oag_pkg::OAG_M_REG && i_kind == oag_pkg::OAG_K_JUMP
			|=> o_pc_we && o_pc == $past(i_reg_val) && o_fetch_addr == {o_pc, 1'b0};
	endproperty
	a_regjmp: assert property (p_regjmp) else $error("register jump target wrong");
	property p_disp;
		take && data && i_mode == oag_pkg::OAG_M_DISP
			|=> o_mem_req && o_mem_addr == {1'b0, $past(i_ext) + $past(i_reg_val)};
	endproperty
	a_disp: assert property (p_disp) else $error("displaced address wrong");
	property p_post;
		take && data && i_mode == oag_pkg::OAG_M_POSTINC |=> o_mem_req && o_mem_addr == {1'b0, $past(i_reg_val)};
	endproperty
	a_post: assert property (p_post) else $error("postincrement address wrong");
	property p_illegal;
		take && i_mode == oag_pkg::OAG_M_PREDEC && (!data || !i_is_move || i_dst_mem)
			|=> o_illegal && !o_mem_req && !o_busy;
	endproperty
	a_illegal: assert property (p_illegal) else $error("predecrement form not refused");
	property p_lane;
		o_mem_req && o_mem_we && o_mem_be != oag_pkg::OAG_BE_WORD |-> o_mem_wdata[15:8] == o_mem_wdata[7:0];
	endproperty
	a_lane: assert property (p_lane) else $error("byte store lanes differ");
endmodule : oag_core_checker
bind oag_core oag_core_checker u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(i_start), .i_iw(i_iw),
	.i_ext(i_ext), .i_mode(i_mode), .i_kind(i_kind), .i_is_move(i_is_move), .i_dst_mem(i_dst_mem),
	.i_reg_val(i_reg_val), .o_busy(o_busy), .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr),
	.o_mem_we(o_mem_we), .o_mem_be(o_mem_be), .o_mem_wdata(o_mem_wdata), .o_result_vld(o_result_vld),
	.o_result(o_result), .o_pc_we(o_pc_we), .o_pc(o_pc), .o_fetch_addr(o_fetch_addr), .o_illegal(o_illegal));

// [test/testbench.sv]
// Self-checking bench for the operand address sequencer
`timescale 1ns/10ps
module testbench;
	logic i_clk = 1'b0, i_rst_n = 1'b0, i_start = 1'b0, i_byte = 1'b0, i_is_move = 1'b0, i_dst_mem = 1'b0;
	logic [15:0] i_iw = 16'h0000, i_ext = 16'h0000, i_reg_val = 16'h0000, i_store_data = 16'h0000;
	oag_pkg::oag_mode_t i_mode = oag_pkg::OAG_M_IMM16;
	oag_pkg::oag_kind_t i_kind = oag_pkg::OAG_K_DATA;
	logic [3:0] lat = 4'h0;
	logic i_mem_ack, o_busy, o_mem_req, o_mem_we, o_result_vld, o_ptr_we, o_pc_we, o_illegal;
	logic [15:0] i_mem_rdata, o_mem_wdata, o_result, o_ptr_wdata, o_pc;
	logic [16:0] o_mem_addr, o_fetch_addr, r_addr;
	logic [1:0] o_mem_be, r_be;
	logic r_vld, r_pc, r_ill, r_req;
	int bad_count = 0, checks_done = 0, r_ptr;
	always #4 i_clk = ~i_clk;
	oag_core DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(i_start), .i_iw(i_iw), .i_ext(i_ext),
		.i_mode(i_mode), .i_kind(i_kind), .i_byte(i_byte), .i_is_move(i_is_move), .i_dst_mem(i_dst_mem),
		.i_reg_val(i_reg_val), .i_store_data(i_store_data), .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata),
		.o_busy(o_busy), .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr), .o_mem_we(o_mem_we),
		.o_mem_be(o_mem_be), .o_mem_wdata(o_mem_wdata), .o_result_vld(o_result_vld), .o_result(o_result),
		.o_ptr_we(o_ptr_we), .o_ptr_wdata(o_ptr_wdata), .o_pc_we(o_pc_we), .o_pc(o_pc),
		.o_fetch_addr(o_fetch_addr), .o_illegal(o_illegal));
	oag_mem_model mem_u (.i_clk(i_clk), .i_req(o_mem_req), .i_addr(o_mem_addr), .i_we(o_mem_we),
		.i_be(o_mem_be), .i_wdata(o_mem_wdata), .i_lat(lat), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic op(input oag_pkg::oag_mode_t m, input oag_pkg::oag_kind_t k, input logic [2:0] f,
		input logic [15:0] iw, input logic [15:0] ext, input logic [15:0] rv, input logic [15:0] sd);
		int n;
		@(negedge i_clk);
		i_mode = m;
		i_kind = k;
		{i_byte, i_is_move, i_dst_mem} = f;
		i_iw = iw;
		i_ext = ext;
		i_reg_val = rv;
		i_store_data = sd;
		i_start = 1'b1;
		{r_vld, r_pc, r_ill, r_req, r_ptr} = '0;
		@(negedge i_clk);
		i_start = 1'b0;
		for (n = 0; n < 20; n++) begin
			r_vld |= o_result_vld;
			r_pc |= o_pc_we;
			r_ill |= o_illegal;
			r_ptr += int'(o_ptr_we);
			if (o_mem_req === 1'b1)
				{r_req, r_addr, r_be} = {1'b1, o_mem_addr, o_mem_be};
			if (o_busy === 1'b0 && o_mem_req === 1'b0)
				break;
			@(negedge i_clk);
		end
		if (n == 20) begin
			bad_count++;
			test_done();
		end
	endtask : op
	task automatic t_immediates();
		op(oag_pkg::OAG_M_IMM16, oag_pkg::OAG_K_DATA, 3'h0, 16'h12A5, 16'hC3F0, 16'h0000, 16'h0000);
		chk("imm16", 17'h0C3F0, o_result);
		op(oag_pkg::OAG_M_IMM8, oag_pkg::OAG_K_DATA, 3'h0, 16'hA55A, 16'hFFFF, 16'h0000, 16'h0000);
		chk("imm8", 17'h0005A, o_result);
		op(oag_pkg::OAG_M_IMM4, oag_pkg::OAG_K_DATA, 3'h0, 16'h12C3, 16'hFFFF, 16'h0000, 16'h0000);
		chk("imm4", 17'h0000C, o_result);
		chk("imm4 valid", 17'h00001, r_vld);
		$display("t_immediates done");
	endtask : t_immediates
	task automatic t_register();
		op(oag_pkg::OAG_M_REG, oag_pkg::OAG_K_DATA, 3'h6, 16'h0000, 16'h0000, 16'hBE7F, 16'h0000);
		chk("reg byte", 17'h0007F, o_result);
		op(oag_pkg::OAG_M_REG, oag_pkg::OAG_K_JUMP, 3'h0, 16'h0000, 16'h0000, 16'h9FD0, 16'h0000);
		chk("reg jump pc", 17'h09FD0, o_pc);
		chk("reg jump fetch", 17'h13FA0, o_fetch_addr);
		$display("t_register done");
	endtask : t_register
	task automatic t_post_pre();
		mem_u.mem[8'h00] = 16'h1234;
		lat = 4'h3;
		op(oag_pkg::OAG_M_POSTINC, oag_pkg::OAG_K_DATA, 3'h2, 16'h0000, 16'h0000, 16'h8000, 16'h0000);
		chk("post addr", 17'h08000, r_addr);
		chk("post data", 17'h01234, o_result);
		chk("post ptr", 17'h08002, o_ptr_wdata);
		op(oag_pkg::OAG_M_PREDEC, oag_pkg::OAG_K_DATA, 3'h6, 16'h0000, 16'h0000, 16'h8002, 16'h0000);
		chk("pre addr", 17'h08001, r_addr);
		chk("pre data", 17'h00034, o_result);
		chk("pre ptr", 17'h08001, o_ptr_wdata);
		chk("pre ptr count", 17'h00001, r_ptr);
		lat = 4'h0;
		$display("t_post_pre done");
	endtask : t_post_pre
	task automatic t_disp_jump();
		mem_u.mem[8'h80] = 16'hF000;
		op(oag_pkg::OAG_M_DISP, oag_pkg::OAG_K_JUMP, 3'h0, 16'h0000, 16'h0200, 16'h8500, 16'h0000);
		chk("djump addr", 17'h08700, r_addr);
		chk("djump fetch", 17'h1E000, o_fetch_addr);
		chk("djump ptr", 17'h00000, r_ptr);
		$display("t_disp_jump done");
	endtask : t_disp_jump
	task automatic t_byte_store();
		mem_u.mem[8'h82] = 16'h1234;
		op(oag_pkg::OAG_M_DISP, oag_pkg::OAG_K_DATA, 3'h7, 16'h0000, 16'h0103, 16'h8402, 16'h00AB);
		chk("bstore addr", 17'h08505, r_addr);
		chk("bstore lane", 17'h00001, r_be);
		chk("bstore mem", 17'h012AB, mem_u.mem[8'h82]);
		$display("t_byte_store done");
	endtask : t_byte_store
	task automatic t_far_move_instruction_illegal();
		op(oag_pkg::OAG_M_IND, oag_pkg::OAG_K_FAR_MOVE_INSTRUCTION, 3'h2, 16'h0000, 16'h0000, 16'h9FD0, 16'h0000);
		chk("far_move_instruction addr", 17'h13FA0, r_addr);
		op(oag_pkg::OAG_M_PREDEC, oag_pkg::OAG_K_DATA, 3'h3, 16'h0000, 16'h0000, 16'h8002, 16'h0000);
		chk("predec refused", 17'h00002, {r_ill, r_req});
		chk("predec no ptr", 17'h00000, r_ptr);
		op(oag_pkg::OAG_M_IND, oag_pkg::OAG_K_JUMP, 3'h0, 16'h0000, 16'h0000, 16'h9FD0, 16'h0000);
		chk("ijump fetch", 17'h13FA0, o_fetch_addr);
		chk("ijump no access", 17'h00000, r_req);
		op(oag_pkg::OAG_M_POSTINC, oag_pkg::OAG_K_JUMP, 3'h0, 16'h0000, 16'h0000, 16'h4000, 16'h0000);
		chk("pjump pc", 17'h04000, o_pc);
		chk("pjump ptr", 17'h04002, o_ptr_wdata);
		chk("pjump ptr count", 17'h00001, r_ptr);
		$display("t_far_move_instruction_illegal done");
	endtask : t_far_move_instruction_illegal
	initial begin
		repeat (8) @(posedge i_clk);
		@(negedge i_clk);
		i_rst_n = 1'b1;
		t_immediates();
		t_register();
		t_post_pre();
		t_disp_jump();
		t_byte_store();
		t_far_move_instruction_illegal();
		test_done();
	end
endmodule : testbench
